// ### hw/display_line_fetch_setup.sv
`timescale 1ns/1ps
`default_nettype none

module display_line_fetch_setup
  import line_fetch_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        mem_valid,
  input  wire logic [63:0] mem_data,
  input  wire logic        comp_valid,
  output logic             fetch_req,
  output logic      [21:0] fetch_addr,
  output logic      [8:0]  fetch_qwords,
  output logic      [21:0] comp_addr,
  output logic             fifo_wr,
  output logic      [63:0] fifo_data,
  output logic      [3:0]  pixel_offset,
  output logic      [20:0] video_buffer_bytes,
  output logic             hsync,
  output logic             vsync,
  output logic             blank
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [31:0] frame_start_q;
  logic [31:0] comp_start_q;
  logic [31:0] line_increment_q;
  logic [31:0] buffer_sizes_q;
  logic [31:0] horizontal_timing_one_q;
  logic [31:0] vert_timing_q;
  logic [31:0] control_q;
  logic        overflow_q;
  logic [31:0] rdata_q;

  // Exact compare; a partial decode would alias the reserved slot
  function automatic logic addr_hit(input logic [15:0] addr,
                                    input logic [15:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  wire hit_frame_start = reg_wr && addr_hit(reg_addr, OFS_FRAME_START);
  wire hit_comp_start  = reg_wr && addr_hit(reg_addr, OFS_COMP_START);
  wire hit_line_inc    = reg_wr && addr_hit(reg_addr, OFS_LINE_INCREMENT);
  wire hit_buf_sizes   = reg_wr && addr_hit(reg_addr, OFS_BUFFER_SIZES);
  wire hit_horiz       = reg_wr && addr_hit(reg_addr, OFS_HORIZ_TIMING);
  wire hit_vert        = reg_wr && addr_hit(reg_addr, OFS_VERT_TIMING);
  wire hit_control     = reg_wr && addr_hit(reg_addr, OFS_CONTROL);
  wire hit_status      = reg_wr && addr_hit(reg_addr, OFS_STATUS);

  wire        timing_en     = control_q[CTL_ENABLE];
  wire        interlaced    = control_q[CTL_INTERLACE];
  wire        panning       = control_q[CTL_PANNING];
  wire [10:0] comp_inc      = line_increment_q[COMP_INC_MSB:COMP_INC_LSB];
  wire [10:0] frame_inc     = line_increment_q[FRAME_INC_MSB:FRAME_INC_LSB];
  wire [13:0] vidbuf_segs   = buffer_sizes_q[VIDBUF_MSB:VIDBUF_LSB];
  wire [6:0]  comp_size     = buffer_sizes_q[COMP_SIZE_MSB:COMP_SIZE_LSB];
  wire [8:0]  fetch_size    = buffer_sizes_q[FETCH_SIZE_MSB:FETCH_SIZE_LSB];
  wire [7:0]  h_total       = horizontal_timing_one_q[HTOTAL_MSB:HTOTAL_LSB];
  wire [7:0]  h_active      = horizontal_timing_one_q[HACTIVE_MSB:HACTIVE_LSB];
  wire [10:0] v_total       = vert_timing_q[VTOTAL_MSB:VTOTAL_LSB];
  wire [10:0] v_active      = vert_timing_q[VACTIVE_MSB:VACTIVE_LSB];

  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_start_q           <= RESET_ZERO;
      comp_start_q            <= RESET_ZERO;
      line_increment_q        <= RESET_ZERO;
      buffer_sizes_q          <= RESET_ZERO;
      horizontal_timing_one_q <= RESET_ZERO;
      vert_timing_q           <= RESET_ZERO;
      control_q               <= RESET_ZERO;
    end else begin
      if (hit_frame_start) frame_start_q <= reg_wdata & MASK_START_OFFSET;
      if (hit_comp_start)  comp_start_q <= reg_wdata & MASK_START_OFFSET;
      if (hit_line_inc)    line_increment_q <= reg_wdata & MASK_LINE_INCREMENT;
      if (hit_buf_sizes)   buffer_sizes_q <= reg_wdata & MASK_BUFFER_SIZES;
      if (hit_horiz)       horizontal_timing_one_q <= reg_wdata & MASK_HORIZ_TIMING;
      if (hit_vert)        vert_timing_q <= reg_wdata & MASK_VERT_TIMING;
      if (hit_control)     control_q <= reg_wdata & MASK_CONTROL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character clock and raster counters

  function automatic logic in_window(input logic [10:0] cnt,
                                     input logic [10:0] start,
                                     input logic [10:0] len);
    in_window = (cnt >= start) && (cnt < 11'(start + len));
  endfunction : in_window

  logic [2:0]  pix_cnt_q;
  logic [7:0]  h_cnt_q;
  logic [10:0] v_cnt_q;

  wire char_en    = timing_en && (pix_cnt_q == PIXELS_PER_CHAR_M1);
  wire line_end   = char_en && (h_cnt_q == h_total);
  wire [10:0] v_step = interlaced ? 11'h002 : 11'h001;
  wire [10:0] v_next = 11'(v_cnt_q + v_step);
  wire frame_end  = line_end && (v_next > v_total);
  wire line_start = char_en && (h_cnt_q == 8'h00);
  wire v_disp     = (v_cnt_q <= v_active);
  wire h_disp     = (h_cnt_q <= h_active);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pix_cnt_q <= 3'h0;
    end else if (!timing_en) begin
      pix_cnt_q <= 3'h0;
    end else begin
      pix_cnt_q <= 3'(pix_cnt_q + 3'h1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      h_cnt_q <= 8'h00;
      v_cnt_q <= 11'h000;
    end else if (!timing_en) begin
      h_cnt_q <= 8'h00;
      v_cnt_q <= 11'h000;
    end else if (char_en) begin
      h_cnt_q <= line_end ? 8'h00 : 8'(h_cnt_q + 8'h01);
      if (line_end) begin
        v_cnt_q <= frame_end ? 11'h000 : v_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync and blank

  // Sync offsets are fixed; a short total simply never reaches them
  wire [10:0] hs_start = 11'(11'(h_active) + 11'(HSYNC_GAP_CHARS));
  wire [10:0] vs_start = 11'(v_active + VSYNC_GAP_LINES);
  wire hsync_d = timing_en && in_window(11'(h_cnt_q), hs_start, 11'(HSYNC_WIDTH_CHARS));
  wire vsync_d = timing_en && in_window(v_cnt_q, vs_start, VSYNC_WIDTH_LINES);
  wire blank_d = !(timing_en && h_disp && v_disp);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hsync <= 1'b0;
      vsync <= 1'b0;
    end else begin
      hsync <= hsync_d;
      vsync <= vsync_d;
    end
  end

  // Blank stays high in reset so the panel never shows garbage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blank <= 1'b1;
    end else begin
      blank <= blank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line pointers and fetch requests

  logic [21:0] frame_ptr_q;
  logic [21:0] comp_ptr_q;
  logic        advance_q;

  // A start offset write moves the pointer at the next frame start, or at once while timing is off
  wire [21:0] frame_base = {frame_start_q[START_ADDR_MSB:START_ADDR_LSB], 4'h0};
  wire [21:0] comp_base  = comp_start_q[21:0];
  wire        fetch_now  = line_start && v_disp;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_ptr_q <= 22'h000000;
      comp_ptr_q  <= 22'h000000;
      advance_q   <= 1'b0;
    end else begin
      // One cycle late, so the fetch below still sees the old pointer
      advance_q <= fetch_now;
      if (frame_end || !timing_en) begin
        frame_ptr_q <= frame_base;
        comp_ptr_q  <= comp_base;
      end else if (advance_q) begin
        frame_ptr_q <= 22'(frame_ptr_q + {9'h000, frame_inc, 2'h0});
        comp_ptr_q  <= 22'(comp_ptr_q + {9'h000, comp_inc, 2'h0});
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_req    <= 1'b0;
      fetch_addr   <= 22'h000000;
      fetch_qwords <= 9'h000;
      comp_addr    <= 22'h000000;
    end else begin
      fetch_req <= fetch_now;
      if (fetch_now) begin
        fetch_addr   <= frame_ptr_q;
        fetch_qwords <= fetch_size;
        comp_addr    <= comp_ptr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Returned data: keep one line's worth, drop the rest

  logic [8:0] recv_cnt_q;

  // One QWORD carries one character clock of pixels; more than that is surplus
  wire [8:0] needed_qwords = panning ? 9'(h_active) + 9'h001 : fetch_size;
  wire       keep_word     = mem_valid && (recv_cnt_q < needed_qwords);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      recv_cnt_q <= 9'h000;
      fifo_wr    <= 1'b0;
      fifo_data  <= 64'h0;
    end else begin
      if (fetch_now) begin
        recv_cnt_q <= 9'h000;
      end else if (mem_valid && (recv_cnt_q != 9'h1ff)) begin
        recv_cnt_q <= 9'(recv_cnt_q + 9'h001);
      end
      fifo_wr <= keep_word;
      if (keep_word) begin
        fifo_data <= mem_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compressed FIFO overflow watch

  logic [6:0] comp_cnt_q;

  // Field holds size plus one; reaching it means one entry too many
  wire comp_overflow = comp_valid && (comp_size != 7'h00) &&
                       (7'(comp_cnt_q + 7'h01) >= comp_size);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      comp_cnt_q <= 7'h00;
      overflow_q <= 1'b0;
    end else begin
      if (fetch_now) begin
        comp_cnt_q <= 7'h00;
      end else if (comp_valid && (comp_cnt_q != COMP_SIZE_LIMIT)) begin
        comp_cnt_q <= 7'(comp_cnt_q + 7'h01);
      end
      // Set beats a same-cycle write-one clear
      if (comp_overflow) begin
        overflow_q <= 1'b1;
      end else if (hit_status && reg_wdata[STS_OVERFLOW]) begin
        overflow_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side outputs and read port

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pixel_offset <= 4'h0;
    end else begin
      // Pixel offset applies at once, unlike the start address
      pixel_offset <= frame_start_q[3:0];
    end
  end

  // Top bit spare: fourteen segment bits stop just short of 1 MB
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      video_buffer_bytes <= 21'h000000;
    end else begin
      video_buffer_bytes <= {1'b0, vidbuf_segs, 6'h00};
    end
  end

  wire [31:0] status_word    = {30'h0, !v_disp, overflow_q};
  wire [31:0] frame_ptr_word = {10'h000, frame_ptr_q};
  wire [31:0] comp_ptr_word  = {10'h000, comp_ptr_q};

  // Unmapped and reserved offsets fall through to zero

  wire [31:0] rdata_d =
    addr_hit(reg_addr, OFS_FRAME_START)    ? frame_start_q           :
    addr_hit(reg_addr, OFS_COMP_START)     ? comp_start_q            :
    addr_hit(reg_addr, OFS_LINE_INCREMENT) ? line_increment_q        :
    addr_hit(reg_addr, OFS_BUFFER_SIZES)   ? buffer_sizes_q          :
    addr_hit(reg_addr, OFS_HORIZ_TIMING)   ? horizontal_timing_one_q :
    addr_hit(reg_addr, OFS_VERT_TIMING)    ? vert_timing_q           :
    addr_hit(reg_addr, OFS_CONTROL)        ? control_q               :
    addr_hit(reg_addr, OFS_STATUS)         ? status_word             :
    addr_hit(reg_addr, OFS_FRAME_POINTER)  ? frame_ptr_word          :
    addr_hit(reg_addr, OFS_COMP_POINTER)   ? comp_ptr_word           :
                                             RESET_ZERO;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= RESET_ZERO;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= RESET_ZERO;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : display_line_fetch_setup

`default_nettype wire

// ### hw/line_fetch_pkg.sv
package line_fetch_pkg;

  // Register offsets (byte addresses within the graphics register space)
  localparam logic [15:0] OFS_FRAME_START     = 16'h8310;
  localparam logic [15:0] OFS_COMP_START      = 16'h8314;
  localparam logic [15:0] OFS_LINE_INCREMENT  = 16'h8324;
  localparam logic [15:0] OFS_BUFFER_SIZES    = 16'h8328;
  localparam logic [15:0] OFS_RESERVED_832C   = 16'h832c;
  localparam logic [15:0] OFS_HORIZ_TIMING    = 16'h8330;
  localparam logic [15:0] OFS_VERT_TIMING     = 16'h8380;
  localparam logic [15:0] OFS_CONTROL         = 16'h8384;
  localparam logic [15:0] OFS_STATUS          = 16'h8388;
  localparam logic [15:0] OFS_FRAME_POINTER   = 16'h838c;
  localparam logic [15:0] OFS_COMP_POINTER    = 16'h8390;

  // Writable-bit masks; reserved bits store nothing and read as zero
  localparam logic [31:0] MASK_START_OFFSET   = 32'h003f_ffff;
  localparam logic [31:0] MASK_LINE_INCREMENT = 32'h007f_f7ff;
  localparam logic [31:0] MASK_BUFFER_SIZES   = 32'h3fff_ffff;
  localparam logic [31:0] MASK_HORIZ_TIMING   = 32'h07f8_07f8;
  localparam logic [31:0] MASK_VERT_TIMING    = 32'h07ff_07ff;
  localparam logic [31:0] MASK_CONTROL        = 32'h0000_0007;

  // Field positions
  localparam int COMP_INC_LSB   = 12;
  localparam int COMP_INC_MSB   = 22;
  localparam int FRAME_INC_LSB  = 0;
  localparam int FRAME_INC_MSB  = 10;
  localparam int VIDBUF_LSB     = 16;
  localparam int VIDBUF_MSB     = 29;
  localparam int COMP_SIZE_LSB  = 9;
  localparam int COMP_SIZE_MSB  = 15;
  localparam int FETCH_SIZE_LSB = 0;
  localparam int FETCH_SIZE_MSB = 8;
  localparam int HTOTAL_LSB     = 19;
  localparam int HTOTAL_MSB     = 26;
  localparam int HACTIVE_LSB    = 3;
  localparam int HACTIVE_MSB    = 10;
  localparam int VTOTAL_LSB     = 16;
  localparam int VTOTAL_MSB     = 26;
  localparam int VACTIVE_LSB    = 0;
  localparam int VACTIVE_MSB    = 10;
  localparam int START_ADDR_LSB = 4;
  localparam int START_ADDR_MSB = 21;
  localparam int CTL_ENABLE     = 0;
  localparam int CTL_INTERLACE  = 1;
  localparam int CTL_PANNING    = 2;
  localparam int STS_OVERFLOW   = 0;
  localparam int STS_VBLANK     = 1;

  // Reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  // Timing counts, size limit and segment shift
  localparam logic [2:0]  PIXELS_PER_CHAR_M1 = 3'h7;
  localparam logic [7:0]  HSYNC_GAP_CHARS    = 8'h02;
  localparam logic [7:0]  HSYNC_WIDTH_CHARS  = 8'h0c;
  localparam logic [10:0] VSYNC_GAP_LINES    = 11'h003;
  localparam logic [10:0] VSYNC_WIDTH_LINES  = 11'h002;
  localparam logic [6:0]  COMP_SIZE_LIMIT    = 7'h41;
  localparam int          VIDBUF_SEG_SHIFT   = 6;

endpackage : line_fetch_pkg

// ### tb/line_fetch_sva.sv
`timescale 1ns/1ps
`default_nettype none
module line_fetch_sva
  import line_fetch_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mem_valid,
  input wire logic [63:0] mem_data,
  input wire logic        fetch_req,
  input wire logic [21:0] fetch_addr,
  input wire logic [8:0]  fetch_qwords,
  input wire logic [21:0] comp_addr,
  input wire logic        fifo_wr,
  input wire logic [63:0] fifo_data,
  input wire logic [3:0]  pixel_offset,
  input wire logic [20:0] video_buffer_bytes,
  input wire logic        hsync,
  input wire logic        vsync,
  input wire logic        blank
);
  logic [9:0]  kept_q;
  logic [31:0] wd1_q;
  logic [31:0] wd2_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Write data delayed twice, since $past takes no slice
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kept_q <= 10'h000;
      wd1_q  <= 32'h0000_0000;
      wd2_q  <= 32'h0000_0000;
    end else begin
      kept_q <= fetch_req ? 10'h000 : kept_q + {9'h000, fifo_wr};
      wd1_q  <= reg_wdata;
      wd2_q  <= wd1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_fetch_pulse: assert property (fetch_req |=> !fetch_req [*8])
    else $error("fetch request too close");
  chk_addr_hold: assert property ($changed(fetch_addr) || $changed(comp_addr) |-> fetch_req)
    else $error("line address moved without fetch");
  chk_fifo_source: assert property (fifo_wr |-> $past(mem_valid) && fifo_data == $past(mem_data))
    else $error("fifo word not from memory");
  chk_kept_bound: assert property (!fetch_req |-> kept_q <= {1'b0, fetch_qwords})
    else $error("more words kept than fetched");
  chk_hsync_blank: assert property (hsync |-> blank)
    else $error("horizontal sync in active region");
  chk_vsync_blank: assert property (vsync |-> blank)
    else $error("vertical sync in active region");
  chk_vbuf_bytes: assert property (reg_wr && reg_addr == OFS_BUFFER_SIZES |-> ##2
    video_buffer_bytes == {1'b0, wd2_q[29:16], 6'h00})
    else $error("video buffer bytes wrong");
  chk_pixel_offset: assert property (reg_wr && reg_addr == OFS_FRAME_START |-> ##2
    pixel_offset == wd2_q[3:0])
    else $error("pixel offset not immediate");
  cover property (fetch_req);
  cover property (fifo_wr ##1 fifo_wr);
  cover property (vsync);
endmodule : line_fetch_sva
bind display_line_fetch_setup line_fetch_sva i_line_fetch_sva (.*);
`default_nettype wire

// ### tb/frame_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module frame_memory_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        fetch_req,
  input  wire logic [21:0] fetch_addr,
  input  wire logic [8:0]  fetch_qwords,
  input  wire logic [3:0]  comp_burst,
  input  wire logic        slow,
  output logic             mem_valid,
  output logic      [63:0] mem_data,
  output logic             comp_valid
);
  logic [8:0]  left_q;
  logic [3:0]  comp_left_q;
  logic [21:0] addr_q;
  logic [1:0]  wait_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {mem_valid, comp_valid, left_q, comp_left_q, addr_q, wait_q} <= '0;
      mem_data <= 64'h0;
    end else begin
      mem_valid  <= 1'b0;
      comp_valid <= 1'b0;
      // Idle bus toggles so stale data never passes
      mem_data   <= ~mem_data;
      wait_q     <= wait_q + 2'h1;
      if (fetch_req) begin
        left_q      <= fetch_qwords;
        addr_q      <= fetch_addr;
        comp_left_q <= comp_burst;
      end else begin
        // Slow mode answers one word in four cycles
        if (left_q != 9'h0 && (!slow || wait_q == 2'h3)) begin
          mem_valid <= 1'b1;
          mem_data  <= {42'h0, addr_q};
          addr_q    <= addr_q + 22'h8;
          left_q    <= left_q - 9'h1;
        end
        if (comp_left_q != 4'h0) begin
          comp_valid  <= 1'b1;
          comp_left_q <= comp_left_q - 4'h1;
        end
      end
    end
  end
endmodule : frame_memory_model
`default_nettype wire

// ### tb/display_line_fetch_setup_bench.sv
`timescale 1ns/1ps
`default_nettype none
module display_line_fetch_setup_bench;
  import line_fetch_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, mem_valid, comp_valid, slow;
  logic        fetch_req, fifo_wr, hsync, vsync, blank;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, st;
  logic [63:0] mem_data, fifo_data;
  logic [21:0] fetch_addr, comp_addr;
  logic [20:0] video_buffer_bytes;
  logic [8:0]  fetch_qwords;
  logic [3:0]  pixel_offset, comp_burst;
  int          mismatches, samples_checked, kept_words;
  display_line_fetch_setup i_display_line_fetch_setup (.*);
  frame_memory_model       i_frame_memory_model (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) kept_words <= fetch_req ? 0 : kept_words + int'(fifo_wr);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // Gap of zero skips the spacing and kept-word checks
  task automatic line_fetch(input logic [21:0] fa, ca, input int gap, kept);
    int n, k;
    n = 0;
    do begin @(posedge ref_clk); n++; k = kept_words; end while (!fetch_req && n < 400);
    if (!fetch_req) begin check("fetch_req", 1, 0); give_verdict(); end
    #1;
    check("fetch_addr", fa, fetch_addr);
    check("comp_addr", ca, comp_addr);
    check("fetch_qwords", 4, fetch_qwords);
    if (gap > 0) check("line gap", gap, n);
    if (gap > 0) check("kept words", kept, k);
  endtask : line_fetch
  task automatic setup(input logic [31:0] ctl, input logic [6:0] cs, input logic [31:0] h);
    reg_write(OFS_CONTROL, 32'h0);
    reg_write(OFS_FRAME_START, 32'h1000);
    reg_write(OFS_COMP_START, 32'h2000);
    reg_write(OFS_LINE_INCREMENT, 32'h0001_0020);
    reg_write(OFS_BUFFER_SIZES, {16'h0003, cs, 9'h004});
    reg_write(OFS_HORIZ_TIMING, h);
    reg_write(OFS_VERT_TIMING, 32'h0005_0002);
    reg_write(OFS_CONTROL, ctl);
  endtask : setup
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_registers;
    logic [15:0] a [8];
    logic [31:0] m [8];
    a = '{16'h8310, 16'h8314, 16'h8324, 16'h8328, 16'h8330, 16'h8380, 16'h832c, 16'h8300};
    m = '{32'h003f_ffff, 32'h003f_ffff, 32'h007f_f7ff, 32'h3fff_ffff, 32'h07f8_07f8, 32'h07ff_07ff, 0, 0};
    for (int i = 0; i < 8; i++) begin
      reg_write(a[i], 32'hffff_ffff);
      reg_read(a[i], st);
      check("register readback", m[i], st);
    end
    check("video_buffer_bytes", 32'h000f_ffc0, video_buffer_bytes);
  endtask : test_registers
  task automatic test_walk;
    setup(32'h1, 7'h0, 32'h0028_0018);
    check("video_buffer_bytes", 32'h0000_00c0, video_buffer_bytes);
    line_fetch(22'h1000, 22'h2000, 0, 0);
    line_fetch(22'h1080, 22'h2040, 48, 4);
    line_fetch(22'h1100, 22'h2080, 48, 4);
    line_fetch(22'h1000, 22'h2000, 192, 4);
    reg_write(OFS_FRAME_START, 32'h3000);
    line_fetch(22'h1080, 22'h2040, 0, 0);
    line_fetch(22'h1100, 22'h2080, 48, 4);
    line_fetch(22'h3000, 22'h2000, 192, 4);
  endtask : test_walk
  task automatic test_panning;
    @(posedge ref_clk) slow <= 1'b1;
    setup(32'h5, 7'h0, 32'h0028_0008);
    line_fetch(22'h1000, 22'h2000, 0, 0);
    line_fetch(22'h1080, 22'h2040, 48, 2);
    @(posedge ref_clk) slow <= 1'b0;
  endtask : test_panning
  task automatic test_interlace;
    setup(32'h3, 7'h0, 32'h0028_0018);
    line_fetch(22'h1000, 22'h2000, 0, 0);
    line_fetch(22'h1080, 22'h2040, 48, 4);
    line_fetch(22'h1000, 22'h2000, 96, 4);
  endtask : test_interlace
  task automatic test_overflow;
    @(posedge ref_clk) comp_burst <= 4'h2;
    setup(32'h1, 7'h3, 32'h0028_0018);
    line_fetch(22'h1000, 22'h2000, 0, 0);
    line_fetch(22'h1080, 22'h2040, 0, 0);
    reg_read(OFS_STATUS, st);
    check("overflow at limit", 0, st[0]);
    @(posedge ref_clk) comp_burst <= 4'h3;
    line_fetch(22'h1100, 22'h2080, 0, 0);
    line_fetch(22'h1000, 22'h2000, 0, 0);
    reg_read(OFS_STATUS, st);
    check("overflow past limit", 1, st[0]);
    @(posedge ref_clk) comp_burst <= 4'h0;
    line_fetch(22'h1080, 22'h2040, 0, 0);
    reg_write(OFS_STATUS, 32'h1);
    reg_read(OFS_STATUS, st);
    check("overflow cleared", 0, st[0]);
  endtask : test_overflow
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_wr, reg_rd, slow} = 4'b1000;
    {reg_addr, reg_wdata, comp_burst} = '0;
    repeat (3) @(posedge ref_clk);
    check("blank in reset", 1, blank);
    rst <= 1'b0;
    test_registers();
    test_walk();
    test_panning();
    test_interlace();
    test_overflow();
    give_verdict();
  end
endmodule : display_line_fetch_setup_bench
`default_nettype wire
